// ==== core/ssfe_fifo.sv ====
// Parameterised FIFO with valid/ready on both sides
`timescale 1ns/1ps
module ssfe_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_data,
	input wire logic i_valid,
	output logic o_ready,
	output logic [W-1:0] o_data,
	output logic o_valid,
	input wire logic i_ready
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0] wp_q;
	logic [AW:0] rp_q;
	logic push;
	logic pop;
	assign o_ready = (wp_q - rp_q) != D[AW:0];
	assign o_valid = wp_q != rp_q;
	assign o_data = mem[rp_q[AW-1:0]];
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wp_q[AW-1:0]] <= i_data;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= rp_q + 1'b1;
			end
		end
	end
endmodule : ssfe_fifo

// ==== core/ssfe_front_end.sv ====
// Serial slave front end of a byte-wide nonvolatile memory
`timescale 1ns/1ps
// Function
// - Serial clock is only an input; the device is always a slave.
// - Data arrives on a serial input and leaves on a separate output.
// - Every byte shifts most significant bit first.
// - First byte after select falls is the operation code.
// - Unknown code locks out input and floats output until reselect.
// - Falling select restarts the command machine and clears lockout.
// - Deselected device ignores input and floats output.
// - Pause pin low freezes bit position and command state.
// - While paused, output floats and input is ignored.
// - Protect pin high allows normal reads and writes.
// - Protect pin low with enable bit one rejects status writes.
// - Protect pin falling during status write selection aborts it.
// - Once the timed status write runs, protect pin is ignored.
// - Enable bit zero makes protect pin irrelevant.
// - Codes have upper nibble zero, bit 3 ignored; six commands.
// - Busy bit reads one during write; all status bits read one.
// - During internal write only status read is obeyed.
// - Write enable latch is clear after power-up.
module ssfe_front_end (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_sel_n,
	input wire logic i_sclk,
	input wire logic i_sdi,
	input wire logic i_pause_n,
	input wire logic i_wprot_n,
	output logic o_sdo,
	output logic o_sdo_oe,
	output logic o_busy,
	output logic o_write_latch,
	output logic [1:0] o_block_protect,
	output logic o_protect_pin_enable_bit,
	output logic o_bad_opcode,
	output logic [7:0] o_rx_data,
	output logic o_rx_valid,
	input wire logic i_rx_ready,
	output logic o_cmd_array_read,
	output logic o_cmd_array_write,
	input wire logic [7:0] i_tx_data
);
	// ----------------------------------------
	// Reset release and pin synchronisers
	// ----------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_n;
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	logic [4:0] meta_q;
	logic [4:0] sync_q;
	logic sclk_prev_q;
	logic wp_prev_q;
	logic sel_prev_q;
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 5'h13;
			sync_q <= 5'h13;
			sclk_prev_q <= 1'b0;
			wp_prev_q <= 1'b1;
			sel_prev_q <= 1'b1;
		end else begin
			meta_q <= {i_sel_n, i_sclk, i_sdi, i_pause_n, i_wprot_n};
			sync_q <= meta_q;
			sclk_prev_q <= sync_q[3];
			wp_prev_q <= sync_q[0];
			sel_prev_q <= sync_q[4];
		end
	end
	logic sel_n;
	logic sclk;
	logic sdi;
	logic pause_n;
	logic wp_n;
	assign {sel_n, sclk, sdi, pause_n, wp_n} = sync_q;
	logic sclk_rise;
	logic sclk_fall;
	logic sel_fall;
	logic wp_fall;
	assign sclk_rise = sclk && !sclk_prev_q;
	assign sclk_fall = !sclk && sclk_prev_q;
	assign sel_fall = !sel_n && sel_prev_q;
	assign wp_fall = !wp_n && wp_prev_q;

	// ----------------------------------------
	// Pause tracking
	// ----------------------------------------
	logic paused_q;
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			paused_q <= 1'b0;
		end else if (sel_n) begin
			paused_q <= 1'b0;
		end else if (!sclk) begin
			paused_q <= !pause_n;
		end
	end
	logic active;
	assign active = !sel_n && !paused_q;

	// ----------------------------------------
	// Command state machine
	// ----------------------------------------
	typedef enum logic [4:0] {
		SSFE_OPCODE = 5'h01,
		SSFE_STREAM = 5'h02,
		SSFE_SRWR = 5'h04,
		SSFE_LOCK = 5'h08,
		SSFE_DONE = 5'h10
	} ssfe_state_t;
	ssfe_state_t state_q;
	logic [2:0] bit_q;
	logic [7:0] shift_q;
	logic [3:0] op_q;
	logic [7:0] sr_new_q;
	logic sr_abort_q;
	logic sr_pend_q;
	logic [7:0] rx_byte;
	logic byte_done;
	assign rx_byte = {shift_q[6:0], sdi};
	assign byte_done = active && sclk_rise && bit_q == 3'h7;

	localparam logic [3:0] OP_SET_WEL = ssfe_pkg::OP_SET_WEL;
	localparam logic [3:0] OP_CLR_WEL = ssfe_pkg::OP_CLR_WEL;
	localparam logic [3:0] OP_STAT_RD = ssfe_pkg::OP_STAT_RD;
	localparam logic [3:0] OP_STAT_WR = ssfe_pkg::OP_STAT_WR;
	localparam logic [3:0] OP_ARR_RD = ssfe_pkg::OP_ARR_RD;
	localparam logic [3:0] OP_ARR_WR = ssfe_pkg::OP_ARR_WR;

	function automatic logic op_known(input logic [7:0] b);
		op_known = b[7:4] == 4'h0 && (b[2:0] == OP_SET_WEL[2:0]
			|| b[2:0] == OP_CLR_WEL[2:0] || b[2:0] == OP_STAT_RD[2:0]
			|| b[2:0] == OP_STAT_WR[2:0] || b[2:0] == OP_ARR_RD[2:0]
			|| b[2:0] == OP_ARR_WR[2:0]);
	endfunction : op_known

	logic busy_q;
	logic wel_q;
	logic [2:0] nv_q;
	logic [7:0] status;
	logic [31:0] twc_q;
	assign status = busy_q ? ssfe_pkg::SR_BUSY_VAL
		: {nv_q[2], 3'h0, nv_q[1:0], wel_q, 1'b0};
	logic hw_prot;
	assign hw_prot = !wp_n && nv_q[2];

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SSFE_OPCODE;
			bit_q <= 3'h0;
			shift_q <= 8'h00;
			op_q <= 4'h0;
			sr_new_q <= 8'h00;
			sr_abort_q <= 1'b0;
		end else if (sel_fall) begin
			state_q <= SSFE_OPCODE;
			bit_q <= 3'h0;
			sr_abort_q <= 1'b0;
		end else if (active && sclk_rise) begin
			bit_q <= bit_q + 3'h1;
			shift_q <= rx_byte;
			if (wp_fall && nv_q[2]) begin
				sr_abort_q <= 1'b1;
			end
			unique case (state_q)
				SSFE_OPCODE: begin
					if (bit_q == 3'h7) begin
						op_q <= {1'b0, rx_byte[2:0]};
						if (!op_known(rx_byte)) begin
							state_q <= SSFE_LOCK;
						end else if (busy_q && rx_byte[2:0] != OP_STAT_RD[2:0]) begin
							state_q <= SSFE_LOCK;
						end else if (rx_byte[2:0] == OP_STAT_WR[2:0]) begin
							state_q <= SSFE_SRWR;
						end else if (rx_byte[2:0] == OP_ARR_RD[2:0]
							|| rx_byte[2:0] == OP_ARR_WR[2:0]
							|| rx_byte[2:0] == OP_STAT_RD[2:0]) begin
							state_q <= SSFE_STREAM;
						end else begin
							state_q <= SSFE_DONE;
						end
					end
				end
				SSFE_SRWR: begin
					if (bit_q == 3'h7) begin
						sr_new_q <= rx_byte;
						state_q <= SSFE_DONE;
					end
				end
				SSFE_STREAM, SSFE_LOCK, SSFE_DONE: begin
				end
			endcase
		end else if (!sel_n && wp_fall && nv_q[2]) begin
			sr_abort_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Latch, nonvolatile bits and write timer
	// ----------------------------------------
	logic sel_rise;
	assign sel_rise = sel_n && !sel_prev_q;
	logic sr_commit;
	assign sr_commit = sel_rise && state_q == SSFE_DONE && op_q == OP_STAT_WR
		&& wel_q && !hw_prot && !sr_abort_q && !busy_q;
	logic arr_commit;
	assign arr_commit = sel_rise && state_q == SSFE_STREAM && op_q == OP_ARR_WR
		&& wel_q && !busy_q;
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wel_q <= 1'b0;
			nv_q <= ssfe_pkg::NV_RESET;
			busy_q <= 1'b0;
			twc_q <= 32'h0;
			sr_pend_q <= 1'b0;
		end else begin
			if (sel_rise && state_q == SSFE_DONE && !busy_q) begin
				if (op_q == OP_SET_WEL) begin
					wel_q <= 1'b1;
				end else if (op_q == OP_CLR_WEL) begin
					wel_q <= 1'b0;
				end
			end
			if (sr_commit || arr_commit) begin
				busy_q <= 1'b1;
				twc_q <= 32'(ssfe_pkg::TWC_CYC - 1);
				sr_pend_q <= sr_commit;
			end else if (busy_q) begin
				if (twc_q == 32'h0) begin
					busy_q <= 1'b0;
					wel_q <= 1'b0;
					sr_pend_q <= 1'b0;
					if (sr_pend_q) begin
						nv_q <= {sr_new_q[ssfe_pkg::SR_PPEN],
							sr_new_q[ssfe_pkg::SR_BP_HI], sr_new_q[ssfe_pkg::SR_BP_LO]};
					end
				end else begin
					twc_q <= twc_q - 32'h1;
				end
			end
		end
	end

	// ----------------------------------------
	// Data streams through the FIFO
	// ----------------------------------------
	logic fifo_ready;
	logic [7:0] fifo_data;
	logic fifo_valid;
	logic push;
	assign push = byte_done && state_q == SSFE_STREAM && op_q == OP_ARR_WR;
	ssfe_fifo #(.W(ssfe_pkg::FIFO_W), .D(ssfe_pkg::FIFO_D)) u_fifo (
		.i_clk(i_ref_clk),
		.i_rst_n(rst_n),
		.i_data(rx_byte),
		.i_valid(push),
		.o_ready(fifo_ready),
		.o_data(fifo_data),
		.o_valid(fifo_valid),
		.i_ready(i_rx_ready && !o_rx_valid)
	);

	// ----------------------------------------
	// Output shifter and registered outputs
	// ----------------------------------------
	logic [7:0] tx_q;
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_q <= 8'h00;
			o_sdo <= 1'b0;
			o_sdo_oe <= 1'b0;
			o_rx_data <= 8'h00;
			o_rx_valid <= 1'b0;
			o_busy <= 1'b0;
			o_write_latch <= 1'b0;
			o_block_protect <= 2'h0;
			o_protect_pin_enable_bit <= 1'b0;
			o_bad_opcode <= 1'b0;
			o_cmd_array_read <= 1'b0;
			o_cmd_array_write <= 1'b0;
		end else begin
			if (byte_done) begin
				tx_q <= (state_q == SSFE_STREAM && op_q == OP_ARR_RD) ? i_tx_data : status;
			end
			if (active && sclk_fall && state_q == SSFE_STREAM && op_q != OP_ARR_WR) begin
				o_sdo <= tx_q[3'h7 - bit_q];
			end
			o_sdo_oe <= active && state_q == SSFE_STREAM
				&& op_q != OP_ARR_WR
				&& (o_sdo_oe || sclk_fall || bit_q != 3'h0);
			if (fifo_valid && i_rx_ready && !o_rx_valid) begin
				o_rx_data <= fifo_data;
				o_rx_valid <= 1'b1;
			end else begin
				o_rx_valid <= 1'b0;
			end
			o_busy <= busy_q;
			o_write_latch <= wel_q;
			o_block_protect <= nv_q[1:0];
			o_protect_pin_enable_bit <= nv_q[2];
			o_bad_opcode <= state_q == SSFE_LOCK;
			o_cmd_array_read <= state_q == SSFE_STREAM && op_q == OP_ARR_RD;
			o_cmd_array_write <= state_q == SSFE_STREAM && op_q == OP_ARR_WR && fifo_ready;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_deselect;
		sel_n;
	endsequence
	AST_FLOAT_DESEL: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		s_deselect |=> !o_sdo_oe) else $error("output driven while deselected");
	AST_FLOAT_PAUSE: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		paused_q |=> !o_sdo_oe) else $error("output driven while paused");
	AST_LOCK_FLOAT: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		state_q == SSFE_LOCK |=> !o_sdo_oe) else $error("output driven after bad code");
	AST_RESTART: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		sel_fall |=> state_q == SSFE_OPCODE && bit_q == 3'h0) else $error("no restart");
	AST_PAUSE_HOLD: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		paused_q && !sel_fall |=> $stable(bit_q)) else $error("bit moved in pause");
	AST_HWPROT: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		sel_rise && state_q == SSFE_DONE && op_q == OP_STAT_WR && hw_prot
		|=> !sr_pend_q) else $error("status write under protection");
	AST_BUSY_ONES: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		byte_done && busy_q
		|=> tx_q == 8'hff) else $error("status not all ones when busy");
	AST_WEL_RESET: assert property (@(posedge i_ref_clk)
		$rose(rst_n) |-> !wel_q) else $error("latch set after reset");
endmodule : ssfe_front_end

// ==== core/ssfe_pkg.sv ====
// Constants for the serial EEPROM front end
package ssfe_pkg;
	// ----------------------------------------
	// Operation codes (low nibble, bit 3 ignored)
	// ----------------------------------------
	localparam logic [3:0] OP_SET_WEL = 4'h6;
	localparam logic [3:0] OP_CLR_WEL = 4'h4;
	localparam logic [3:0] OP_STAT_RD = 4'h5;
	localparam logic [3:0] OP_STAT_WR = 4'h1;
	localparam logic [3:0] OP_ARR_RD = 4'h3;
	localparam logic [3:0] OP_ARR_WR = 4'h2;
	// ----------------------------------------
	// Status register fields
	// ----------------------------------------
	localparam int SR_BUSY = 0;
	localparam int SR_WEL = 1;
	localparam int SR_BP_LO = 2;
	localparam int SR_BP_HI = 3;
	localparam int SR_PPEN = 7;
	localparam logic [7:0] SR_BUSY_VAL = 8'hff;
	localparam logic [2:0] NV_RESET = 3'h0;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 10;
	localparam int TWC_US = 5000;
	localparam int TWC_CYC = TWC_US * CLK_MHZ;
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 16;
endpackage : ssfe_pkg

// ==== sim/spi_eeprom_serial_front_end_test.sv ====
// Self-checking bench for the serial EEPROM front end
`timescale 1ns/1ps
module spi_eeprom_serial_front_end_test;
	localparam int DLY = 1;
	logic clk = 1'b0;
	logic resetn = 1'b1;
	logic wprot_n = 1'b1;
	logic sel_n, sclk, sdi, pause_n, sdo, sdo_oe, busy, wlatch, ppen, bad, rx_valid;
	logic arr_rd, arr_wr;
	logic [1:0] bp;
	logic [7:0] rx_data;
	logic [7:0] v;
	logic oe;
	logic [7:0] rx_seen = 8'h00;
	logic [7:0] rx_count = 8'h00;
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	ssfe_front_end ssfe_front_end_inst (.i_ref_clk(clk), .i_resetn(resetn), .i_sel_n(sel_n),
		.i_sclk(sclk), .i_sdi(sdi), .i_pause_n(pause_n), .i_wprot_n(wprot_n), .o_sdo(sdo),
		.o_sdo_oe(sdo_oe), .o_busy(busy), .o_write_latch(wlatch), .o_block_protect(bp),
		.o_protect_pin_enable_bit(ppen), .o_bad_opcode(bad), .o_rx_data(rx_data),
		.o_rx_valid(rx_valid), .i_rx_ready(1'b1), .o_cmd_array_read(arr_rd),
		.o_cmd_array_write(arr_wr), .i_tx_data(8'hc1));
	ssfe_spi_master ssfe_spi_master_inst (.i_ref_clk(clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe),
		.o_sel_n(sel_n), .o_sclk(sclk), .o_sdi(sdi), .o_pause_n(pause_n));
	initial begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		if (rx_valid === 1'b1) begin
			rx_seen <= rx_data;
			rx_count <= rx_count + 8'h01;
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_of_test();
		if (failures == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test
	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			failures++;
			end_of_test();
		end
	end
	task automatic cmd(input logic [7:0] op);
		ssfe_spi_master_inst.select();
		ssfe_spi_master_inst.xfer(op, 8, v, oe);
		ssfe_spi_master_inst.deselect();
	endtask : cmd
	task automatic rd_status(output logic [7:0] st, output logic st_oe);
		ssfe_spi_master_inst.select();
		ssfe_spi_master_inst.xfer(8'h05, 8, v, oe);
		ssfe_spi_master_inst.xfer(8'h00, 8, st, st_oe);
		ssfe_spi_master_inst.deselect();
	endtask : rd_status
	task automatic t_reset();
		check({5'h00, busy, wlatch, bad}, 8'h00);
		check({7'h00, sdo_oe}, 8'h00);
	endtask : t_reset
	task automatic t_latch();
		cmd(8'h06);
		check({7'h00, wlatch}, 8'h01);
		cmd(8'h04);
		check({7'h00, wlatch}, 8'h00);
		cmd(8'h0e);
		check({7'h00, wlatch}, 8'h01);
		rd_status(v, oe);
		check(v, 8'h02);
		check({7'h00, oe}, 8'h01);
		check({7'h00, sdo_oe}, 8'h00);
	endtask : t_latch
	task automatic t_bad();
		ssfe_spi_master_inst.select();
		ssfe_spi_master_inst.xfer(8'h07, 8, v, oe);
		check({7'h00, bad}, 8'h01);
		ssfe_spi_master_inst.xfer(8'hff, 8, v, oe);
		check({7'h00, oe}, 8'h00);
		ssfe_spi_master_inst.deselect();
		rd_status(v, oe);
		check(v, 8'h02);
		check({7'h00, bad}, 8'h00);
	endtask : t_bad
	task automatic t_pause();
		ssfe_spi_master_inst.select();
		ssfe_spi_master_inst.xfer(8'h05, 4, v, oe);
		check({7'h00, oe}, 8'h00);
		ssfe_spi_master_inst.xfer(8'h00, 8, v, oe);
		ssfe_spi_master_inst.deselect();
		check(v, 8'h02);
	endtask : t_pause
	task automatic t_wsr();
		int n;
		n = 0;
		@(posedge clk) #DLY wprot_n = 1'b0;
		ssfe_spi_master_inst.select();
		ssfe_spi_master_inst.xfer(8'h01, 8, v, oe);
		ssfe_spi_master_inst.xfer(8'h8c, 8, v, oe);
		ssfe_spi_master_inst.deselect();
		check({7'h00, busy}, 8'h01);
		rd_status(v, oe);
		check(v, 8'hff);
		ssfe_spi_master_inst.select();
		ssfe_spi_master_inst.xfer(8'h06, 8, v, oe);
		check({7'h00, bad}, 8'h01);
		ssfe_spi_master_inst.deselect();
		@(posedge clk) #DLY wprot_n = 1'b1;
		repeat (4) @(posedge clk);
		#DLY wprot_n = 1'b0;
		while (busy !== 1'b0 && n < 60000) begin
			@(posedge clk);
			#DLY;
			n++;
		end
		check({5'h00, ppen, bp}, 8'h07);
	endtask : t_wsr
	task automatic t_prot();
		cmd(8'h06);
		ssfe_spi_master_inst.select();
		ssfe_spi_master_inst.xfer(8'h01, 8, v, oe);
		ssfe_spi_master_inst.xfer(8'h00, 8, v, oe);
		ssfe_spi_master_inst.deselect();
		check({5'h00, busy, bp}, 8'h03);
		@(posedge clk) #DLY wprot_n = 1'b1;
		cmd(8'h06);
		ssfe_spi_master_inst.select();
		ssfe_spi_master_inst.xfer(8'h01, 8, v, oe);
		@(posedge clk) #DLY wprot_n = 1'b0;
		ssfe_spi_master_inst.xfer(8'h00, 8, v, oe);
		@(posedge clk) #DLY wprot_n = 1'b1;
		ssfe_spi_master_inst.deselect();
		check({4'h0, busy, ppen, bp}, 8'h07);
	endtask : t_prot
	task automatic t_array();
		cmd(8'h04);
		ssfe_spi_master_inst.select();
		ssfe_spi_master_inst.xfer(8'h02, 8, v, oe);
		check({7'h00, arr_wr}, 8'h01);
		ssfe_spi_master_inst.xfer(8'h4b, 8, v, oe);
		ssfe_spi_master_inst.deselect();
		check(rx_seen, 8'h4b);
		check(rx_count, 8'h01);
		check({7'h00, busy}, 8'h00);
		ssfe_spi_master_inst.select();
		ssfe_spi_master_inst.xfer(8'h03, 8, v, oe);
		check({7'h00, arr_rd}, 8'h01);
		ssfe_spi_master_inst.xfer(8'h00, 8, v, oe);
		ssfe_spi_master_inst.xfer(8'h00, 8, v, oe);
		ssfe_spi_master_inst.deselect();
		check(v, 8'hc1);
	endtask : t_array
	initial begin
		#DLY resetn = 1'b0;
		repeat (12) @(posedge clk);
		#DLY resetn = 1'b1;
		repeat (8) @(posedge clk);
		t_reset();
		t_latch();
		t_bad();
		t_pause();
		t_wsr();
		t_prot();
		t_array();
		end_of_test();
	end
endmodule : spi_eeprom_serial_front_end_test

// ==== sim/ssfe_spi_master.sv ====
// SPI master model driving the front end pins
`timescale 1ns/1ps
module ssfe_spi_master (
	input wire logic i_ref_clk,
	input wire logic i_sdo,
	input wire logic i_sdo_oe,
	output logic o_sel_n,
	output logic o_sclk,
	output logic o_sdi,
	output logic o_pause_n
);
	localparam int HALF_NS = 400;
	logic last_q = 1'b0;
	logic line;
	initial begin
		o_sel_n = 1'b1;
		o_sclk = 1'b0;
		o_sdi = 1'b0;
		o_pause_n = 1'b1;
	end
	// Released line shows the inverse of the last driven level
	always @(posedge i_ref_clk) begin
		if (i_sdo_oe) begin
			last_q <= i_sdo;
		end
	end
	assign line = i_sdo_oe ? i_sdo : ~last_q;
	task automatic select();
		@(posedge i_ref_clk);
		#1;
		o_sel_n = 1'b0;
		#HALF_NS;
	endtask : select
	task automatic deselect();
		#HALF_NS;
		o_sel_n = 1'b1;
		#(4 * HALF_NS);
	endtask : deselect
	// One byte; pause after bit pause_at (8 for none)
	task automatic xfer(input logic [7:0] tx, input int pause_at, output logic [7:0] rx,
		output logic oe_or);
		oe_or = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			o_sdi = tx[i];
			#HALF_NS;
			o_sclk = 1'b1;
			#(HALF_NS - 10);
			rx[i] = line;
			oe_or = oe_or | i_sdo_oe;
			#10;
			o_sclk = 1'b0;
			if (i == pause_at) begin
				#(HALF_NS / 2);
				o_pause_n = 1'b0;
				repeat (3) begin
					#HALF_NS;
					o_sclk = 1'b1;
					o_sdi = ~o_sdi;
					#HALF_NS;
					o_sclk = 1'b0;
					oe_or = oe_or | i_sdo_oe;
				end
				#HALF_NS;
				o_pause_n = 1'b1;
			end
		end
	endtask : xfer
endmodule : ssfe_spi_master
